// ---- pkg/gate_seq_pkg.sv ----
// Constants, register map and state type for the PFC and flyback gate sequencer.
// Assumes a single 50 MHz system clock; all timing counts derive from it.
package gate_seq_pkg;

	// ************************************************************
	// Clock and timing
	// ************************************************************
	localparam int CLK_HZ          = 50_000_000;
	localparam int CLK_NS          = 20;
	localparam int CNT_W           = 12;
	localparam int SUP_TIME_NS     = 2_000;
	localparam int SUP_CYC         = (SUP_TIME_NS + CLK_NS - 1) / CLK_NS;
	localparam int MAX_ON_NS       = 40_000;
	localparam int MAX_ON_CYC      = MAX_ON_NS / CLK_NS;
	localparam int LEB_NS          = 300;
	localparam int LEB_CYC         = (LEB_NS + CLK_NS - 1) / CLK_NS;
	localparam int FB_MAX_HZ       = 125_000;
	localparam int MIN_PERIOD_CYC  = (CLK_HZ + FB_MAX_HZ - 1) / FB_MAX_HZ;
	localparam int PFC_OFF_HZ      = 48_000;
	localparam int PFC_OFF_CYC     = CLK_HZ / PFC_OFF_HZ;
	localparam int PFC_ON_HZ       = 86_000;
	localparam int PFC_ON_CYC      = CLK_HZ / PFC_ON_HZ;

	// ************************************************************
	// Overvoltage filter
	// ************************************************************
	localparam int            OVP_W    = 4;
	localparam logic [3:0]    OVP_TRIP = 4'h8;
	localparam logic [3:0]    OVP_UP   = 4'h1;
	localparam logic [3:0]    OVP_DOWN = 4'h2;

	// ************************************************************
	// Comparator flag positions
	// ************************************************************
	localparam int NFLAG         = 17;
	localparam int F_PFC_OVP     = 0;
	localparam int F_PFC_OL_OK   = 1;
	localparam int F_PFC_REQ     = 2;
	localparam int F_DEMAG       = 3;
	localparam int F_VALLEY      = 4;
	localparam int F_OSC         = 5;
	localparam int F_CS_TRIP     = 6;
	localparam int F_AUX_OPEN    = 7;
	localparam int F_CTRL_2V5    = 8;
	localparam int F_CTRL_4V5    = 9;
	localparam int F_CTRL_SHORT  = 10;
	localparam int F_SS_DONE     = 11;
	localparam int F_VCC_START   = 12;
	localparam int F_FB_OVP      = 13;
	localparam int F_MAINS_LOW   = 14;
	localparam int F_MAINS_HIGH  = 15;
	localparam int F_FREQ_RED    = 16;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [7:0]  ADDR_CTRL       = 8'h00;
	localparam logic [7:0]  ADDR_STATUS     = 8'h04;
	localparam logic [7:0]  ADDR_PERIOD     = 8'h08;
	localparam logic [1:0]  CTRL_RESET      = 2'h3;
	localparam int          CTRL_FB_EN      = 0;
	localparam int          CTRL_PFC_EN     = 1;
	localparam int          ST_LATCHED      = 0;
	localparam int          ST_RESTARTED    = 1;
	localparam int          ST_PFC_LOW      = 2;
	localparam int          ST_FB_GATE      = 3;
	localparam int          ST_OVP_LSB      = 4;

	typedef enum logic [2:0] {
		FB_SOFTSTART,
		FB_PRIMARY,
		FB_SECONDARY,
		FB_WAIT,
		FB_RESTART
	} fb_state_t;

endpackage : gate_seq_pkg

// ---- logic/flag_sync.sv ----
// Two-stage synchroniser for a vector of comparator flags.
// Assumes each flag is a quasi-static level; bits are synchronised independently.
`timescale 1ns/1ns
`default_nettype none
module flag_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// Flags
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);

	logic [W-1:0] meta;

	// First stage feeds only the second stage
	always_ff @(posedge clk or posedge rst) begin // RULE24
		if (rst) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end

endmodule : flag_sync
`default_nettype wire

// ---- logic/gate_sequencer.sv ----
// Gate sequencing and protection for a combined PFC and flyback controller.
// Assumes comparator flags come from analog blocks and a plain register port.
//
// Behaviour
// RULE1 - PFC stops while output above overvoltage
// RULE2 - PFC waits for output above open-loop level
// RULE3 - flyback period never below 125 kHz
// RULE4 - stroke starts after demagnetization then valley
// RULE5 - stroke needs oscillator high and valley
// RULE6 - demagnetization ignored first 2 us
// RULE7 - open aux sense stops flyback, auto-resumes
// RULE8 - control above 2.5 V drops pull-up
// RULE9 - control above 4.5 V latches protection
// RULE10 - shorted control pin blocks flyback gate
// RULE11 - frequency reduction keeps PFC off, hysteretic
// RULE12 - soft-start until current sense reaches 0.63 V
// RULE13 - on-time capped 40 us, then restart
// RULE14 - overvoltage cycle counts filter up one
// RULE15 - clean cycle counts filter down two
// RULE16 - count eight latches, stops both converters
// RULE17 - mains low-then-high sequence clears latch
// RULE18 - output overvoltage sampled in secondary stroke
// RULE19 - overcurrent ignored during leading-edge blanking
// RULE20 - current trip ends the on-time
// RULE21 - input sensed during primary stroke
// RULE22 - shorted output lengthens off-time via demag
// RULE23 - PFC off below 48 kHz, on above 86 kHz
// RULE24 - flags synchronised, intervals counted in cycles
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ns
`default_nettype none
module gate_sequencer #(
	parameter logic [11:0] SUP_CYC        = 12'(gate_seq_pkg::SUP_CYC),
	parameter logic [11:0] MAX_ON_CYC     = 12'(gate_seq_pkg::MAX_ON_CYC),
	parameter logic [11:0] LEB_CYC        = 12'(gate_seq_pkg::LEB_CYC),
	parameter logic [11:0] MIN_PERIOD_CYC = 12'(gate_seq_pkg::MIN_PERIOD_CYC),
	parameter logic [11:0] PFC_OFF_CYC    = 12'(gate_seq_pkg::PFC_OFF_CYC),
	parameter logic [11:0] PFC_ON_CYC     = 12'(gate_seq_pkg::PFC_ON_CYC)
) (
	// Clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        RST,
	// Comparator flags, see package for bit positions
	input  wire logic [16:0] FLAGS,
	// Gate and analog control outputs
	output var  logic        PFC_GATE,
	output var  logic        FB_GATE,
	output var  logic        FB_CTRL_PULLUP_EN,
	output var  logic        FB_SOFT_START_EN,
	output var  logic        OPP_SAMPLE_EN,
	output var  logic        OVP_SAMPLE_EN,
	output var  logic        PROT_LATCHED,
	// Register port
	input  wire logic [7:0]  REG_ADDR,
	input  wire logic [31:0] REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output var  logic [31:0] REG_RDATA
);

	localparam int W = gate_seq_pkg::CNT_W;

	logic [16:0]                     flag;
	gate_seq_pkg::fb_state_t         state;
	gate_seq_pkg::fb_state_t         next_state;
	logic [W-1:0]                    on_cnt;
	logic [W-1:0]                    sup_cnt;
	logic [W-1:0]                    period_cnt;
	logic [W-1:0]                    last_period;
	logic [3:0]                      ovp_cnt;
	logic                            cycle_ovp;
	logic                            latched;
	logic                            mains_armed;
	logic                            pfc_low;
	logic                            restarted;
	logic [1:0]                      ctrl;
	logic                            run_ok;
	logic                            stroke_start;
	logic                            end_secondary;
	logic                            latch_clear;

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [W-1:0] sat_inc(input logic [W-1:0] v);
		sat_inc = (v == {W{1'b1}}) ? v : v + 1'b1;
	endfunction : sat_inc

	function automatic logic [3:0] ovp_step(input logic [3:0] v, input logic over);
		if (over) begin
			ovp_step = (v >= gate_seq_pkg::OVP_TRIP) ? v : v + gate_seq_pkg::OVP_UP;
		end else begin
			ovp_step = (v < gate_seq_pkg::OVP_DOWN) ? 4'h0 : v - gate_seq_pkg::OVP_DOWN;
		end
	endfunction : ovp_step

	// ************************************************************
	// Flag synchronisation
	// ************************************************************
	flag_sync #(
		.W (gate_seq_pkg::NFLAG)
	) u_sync (
		.clk (REF_CLK),
		.rst (RST),
		.d   (FLAGS),
		.q   (flag)
	);

	wire pfc_ovp    = flag[gate_seq_pkg::F_PFC_OVP];
	wire pfc_ol_ok  = flag[gate_seq_pkg::F_PFC_OL_OK];
	wire pfc_req    = flag[gate_seq_pkg::F_PFC_REQ];
	wire demag      = flag[gate_seq_pkg::F_DEMAG];
	wire valley     = flag[gate_seq_pkg::F_VALLEY];
	wire osc_high   = flag[gate_seq_pkg::F_OSC];
	wire cs_trip    = flag[gate_seq_pkg::F_CS_TRIP];
	wire aux_open   = flag[gate_seq_pkg::F_AUX_OPEN];
	wire ctrl_2v5   = flag[gate_seq_pkg::F_CTRL_2V5];
	wire ctrl_4v5   = flag[gate_seq_pkg::F_CTRL_4V5];
	wire ctrl_short = flag[gate_seq_pkg::F_CTRL_SHORT];
	wire ss_done    = flag[gate_seq_pkg::F_SS_DONE];
	wire vcc_start  = flag[gate_seq_pkg::F_VCC_START];
	wire fb_ovp     = flag[gate_seq_pkg::F_FB_OVP];
	wire mains_low  = flag[gate_seq_pkg::F_MAINS_LOW];
	wire mains_high = flag[gate_seq_pkg::F_MAINS_HIGH];
	wire freq_red   = flag[gate_seq_pkg::F_FREQ_RED];

	// ************************************************************
	// Flyback stroke sequencing
	// ************************************************************
	assign run_ok = ctrl[gate_seq_pkg::CTRL_FB_EN] & ~aux_open & ~ctrl_short // RULE7 RULE10
			& ~latched & ~ctrl_4v5;

	always_comb begin
		next_state = state;
		case (state)
			gate_seq_pkg::FB_SOFTSTART: begin
				if (vcc_start && ss_done && run_ok) begin // RULE12
					next_state = gate_seq_pkg::FB_WAIT;
				end
			end
			gate_seq_pkg::FB_PRIMARY: begin
				if (on_cnt >= MAX_ON_CYC - 12'h001) begin // RULE13
					next_state = gate_seq_pkg::FB_RESTART;
				end else if ((cs_trip && on_cnt >= LEB_CYC) || !run_ok) begin // RULE19 RULE20
					next_state = gate_seq_pkg::FB_SECONDARY;
				end
			end
			gate_seq_pkg::FB_SECONDARY: begin
				// Off-time stretches until demag, which slows a shorted output
				if (sup_cnt >= SUP_CYC && demag) begin // RULE6 RULE22
					next_state = gate_seq_pkg::FB_WAIT;
				end
			end
			gate_seq_pkg::FB_WAIT: begin
				// Early valleys are skipped while the period is too short
				if (osc_high && valley && period_cnt >= MIN_PERIOD_CYC && run_ok) begin // RULE3 RULE4 RULE5
					next_state = gate_seq_pkg::FB_PRIMARY;
				end
			end
			gate_seq_pkg::FB_RESTART: begin
				next_state = gate_seq_pkg::FB_SOFTSTART;
			end
			default: begin
				next_state = gate_seq_pkg::FB_SOFTSTART;
			end
		endcase
		if (latched && state != gate_seq_pkg::FB_PRIMARY) begin // RULE16
			next_state = gate_seq_pkg::FB_SOFTSTART;
		end
	end

	assign stroke_start  = (state == gate_seq_pkg::FB_WAIT) && (next_state == gate_seq_pkg::FB_PRIMARY);
	assign end_secondary = (state == gate_seq_pkg::FB_SECONDARY) && (next_state == gate_seq_pkg::FB_WAIT);

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			state <= gate_seq_pkg::FB_SOFTSTART;
		end else begin
			state <= next_state;
		end
	end

	// ************************************************************
	// Interval counters
	// ************************************************************
	always_ff @(posedge REF_CLK or posedge RST) begin // RULE24
		if (RST) begin
			on_cnt      <= '0;
			sup_cnt     <= '0;
			period_cnt  <= '0;
			last_period <= '0;
		end else begin
			on_cnt  <= (state == gate_seq_pkg::FB_PRIMARY) ? sat_inc(on_cnt) : '0;
			sup_cnt <= (state == gate_seq_pkg::FB_SECONDARY) ? sat_inc(sup_cnt) : '0;
			if (stroke_start) begin
				last_period <= period_cnt;
				period_cnt  <= '0;
			end else begin
				period_cnt <= sat_inc(period_cnt);
			end
		end
	end

	// ************************************************************
	// Gate and analog control outputs
	// ************************************************************
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			FB_GATE           <= 1'b0;
			FB_CTRL_PULLUP_EN <= 1'b1;
			FB_SOFT_START_EN  <= 1'b0;
			OPP_SAMPLE_EN     <= 1'b0;
			OVP_SAMPLE_EN     <= 1'b0;
			PFC_GATE          <= 1'b0;
		end else begin
			FB_GATE           <= (next_state == gate_seq_pkg::FB_PRIMARY);
			FB_CTRL_PULLUP_EN <= ~ctrl_2v5; // RULE8
			FB_SOFT_START_EN  <= vcc_start && (next_state == gate_seq_pkg::FB_SOFTSTART); // RULE12
			OPP_SAMPLE_EN     <= (next_state == gate_seq_pkg::FB_PRIMARY); // RULE21
			OVP_SAMPLE_EN     <= (next_state == gate_seq_pkg::FB_SECONDARY); // RULE18
			PFC_GATE          <= ctrl[gate_seq_pkg::CTRL_PFC_EN] & pfc_req // RULE1 RULE2 RULE11
					& ~pfc_ovp & pfc_ol_ok & ~latched & ~pfc_low;
		end
	end

	// ************************************************************
	// PFC low-power hysteresis
	// ************************************************************
	// Set may come with no stroke at all, since the frequency can reach zero
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			pfc_low <= 1'b0;
		end else if (freq_red && period_cnt > PFC_OFF_CYC) begin // RULE11 RULE23
			pfc_low <= 1'b1;
		end else if (stroke_start && period_cnt < PFC_ON_CYC) begin // RULE23
			pfc_low <= 1'b0;
		end
	end

	// ************************************************************
	// Overvoltage filter and protection latch
	// ************************************************************
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			cycle_ovp <= 1'b0;
		end else if (stroke_start) begin
			cycle_ovp <= 1'b0;
		end else if (state == gate_seq_pkg::FB_SECONDARY && fb_ovp) begin // RULE18
			cycle_ovp <= 1'b1;
		end
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			ovp_cnt <= 4'h0;
		end else if (latch_clear) begin
			ovp_cnt <= 4'h0;
		end else if (end_secondary) begin
			ovp_cnt <= ovp_step(ovp_cnt, cycle_ovp | fb_ovp); // RULE14 RULE15
		end
	end

	assign latch_clear = mains_armed && mains_high && !mains_low;

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			mains_armed <= 1'b0;
		end else if (mains_low) begin
			mains_armed <= 1'b1;
		// Stay armed until the latch has dropped, since a set in the clear cycle wins
		end else if (latch_clear && !latched) begin
			mains_armed <= 1'b0;
		end
	end

	// Set wins over the mains clear
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			latched <= 1'b0;
		end else if (ovp_cnt >= gate_seq_pkg::OVP_TRIP || ctrl_4v5) begin // RULE9 RULE16
			latched <= 1'b1;
		end else if (latch_clear) begin // RULE17
			latched <= 1'b0;
		end
	end

	assign PROT_LATCHED = latched;

	// ************************************************************
	// Register port
	// ************************************************************
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			ctrl <= gate_seq_pkg::CTRL_RESET;
		end else if (REG_WR && REG_ADDR == gate_seq_pkg::ADDR_CTRL) begin
			ctrl <= REG_WDATA[1:0];
		end
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			restarted <= 1'b0;
		end else if (state == gate_seq_pkg::FB_RESTART) begin
			restarted <= 1'b1;
		end else if (REG_WR && REG_ADDR == gate_seq_pkg::ADDR_STATUS
				&& REG_WDATA[gate_seq_pkg::ST_RESTARTED]) begin
			restarted <= 1'b0;
		end
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			REG_RDATA <= 32'h0000_0000;
		end else if (!REG_RD) begin
			REG_RDATA <= 32'h0000_0000;
		end else begin
			case (REG_ADDR)
				gate_seq_pkg::ADDR_CTRL: begin
					REG_RDATA <= {30'h0000_0000, ctrl};
				end
				gate_seq_pkg::ADDR_STATUS: begin
					REG_RDATA <= {24'h00_0000, ovp_cnt, FB_GATE, pfc_low, restarted, latched};
				end
				gate_seq_pkg::ADDR_PERIOD: begin
					REG_RDATA <= {20'h0_0000, last_period};
				end
				default: begin
					REG_RDATA <= 32'h0000_0000;
				end
			endcase
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);

	property p_pfc_ovp;
		pfc_ovp |=> !PFC_GATE;
	endproperty
	a_pfc_ovp: assert property (p_pfc_ovp) else $error("PFC gate on during overvoltage"); // RULE1

	property p_pfc_open_loop;
		!pfc_ol_ok |=> !PFC_GATE;
	endproperty
	a_pfc_open_loop: assert property (p_pfc_open_loop) else $error("PFC gate on below open-loop level"); // RULE2

	property p_min_period;
		(state == gate_seq_pkg::FB_WAIT && period_cnt < MIN_PERIOD_CYC) |=> !FB_GATE;
	endproperty
	a_min_period: assert property (p_min_period) else $error("Flyback period below minimum"); // RULE3

	property p_valley_start;
		$rose(FB_GATE) |-> $past(valley) && $past(osc_high) && $past(state) == gate_seq_pkg::FB_WAIT;
	endproperty
	a_valley_start: assert property (p_valley_start) else $error("Stroke started without valley"); // RULE4 RULE5

	property p_demag_suppress;
		(state == gate_seq_pkg::FB_SECONDARY && sup_cnt < SUP_CYC && !latched)
			|=> state == gate_seq_pkg::FB_SECONDARY;
	endproperty
	a_demag_suppress: assert property (p_demag_suppress) else $error("Demag accepted during suppression"); // RULE6

	property p_aux_open;
		(aux_open || ctrl_short) |=> !FB_GATE;
	endproperty
	a_aux_open: assert property (p_aux_open) else $error("Flyback gate on with pin fault"); // RULE7 RULE10

	property p_pullup;
		ctrl_2v5 |=> !FB_CTRL_PULLUP_EN;
	endproperty
	a_pullup: assert property (p_pullup) else $error("Pull-up kept above 2.5 V"); // RULE8

	property p_ctrl_latch;
		ctrl_4v5 |=> PROT_LATCHED ##1 !FB_GATE;
	endproperty
	a_ctrl_latch: assert property (p_ctrl_latch) else $error("No latch above 4.5 V"); // RULE9

	property p_max_on;
		FB_GATE |-> on_cnt < MAX_ON_CYC;
	endproperty
	a_max_on: assert property (p_max_on) else $error("On-time over maximum"); // RULE13

	property p_ovp_up;
		(end_secondary && (cycle_ovp || fb_ovp) && ovp_cnt < 4'h8 && !latch_clear)
			|=> ovp_cnt == $past(ovp_cnt) + 4'h1;
	endproperty
	a_ovp_up: assert property (p_ovp_up) else $error("Filter did not count up by one"); // RULE14

	property p_ovp_down;
		(end_secondary && !cycle_ovp && !fb_ovp && ovp_cnt >= 4'h2 && !latch_clear)
			|=> ovp_cnt == $past(ovp_cnt) - 4'h2;
	endproperty
	a_ovp_down: assert property (p_ovp_down) else $error("Filter did not count down by two"); // RULE15

	property p_ovp_latch;
		ovp_cnt == 4'h8 |=> PROT_LATCHED ##1 (!PFC_GATE && !FB_GATE);
	endproperty
	a_ovp_latch: assert property (p_ovp_latch) else $error("Count of eight did not latch"); // RULE16

endmodule : gate_sequencer
`default_nettype wire

// ---- dv/flyback_plant.sv ----
// Behavioural flyback power stage: switch current, transformer demagnetisation, drain ringing.
// Assumes the bench sets on-time and secondary length in clock cycles.
`timescale 1ns/1ns
`default_nettype none
module flyback_plant (
	// Clock and gate drive
	input  wire logic        clk,
	input  wire logic        gate,
	// Stroke lengths set by the bench
	input  wire logic [11:0] on_len,
	input  wire logic [11:0] demag_len,
	// Comparator levels
	output var  logic        cs_trip,
	output var  logic        demag,
	output var  logic        valley
);
	logic [11:0] cnt    = 12'h000;
	logic        gate_q = 1'b0;

	// Saturate so a stalled stage never wraps into a false demag
	// Unknown gate before reset counts as a change, so cnt never sticks at X
	always @(posedge clk) begin
		gate_q <= gate;
		cnt    <= (gate !== gate_q) ? 12'h000 : cnt + 12'(cnt != 12'hFFF);
	end

	assign cs_trip = gate && cnt >= on_len;
	assign demag   = !gate && cnt >= demag_len;
	// Ringing: valley toggles every cycle once demagnetised
	assign valley  = demag && cnt[0];
endmodule : flyback_plant
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench for the gate sequencer: flag levels, registers and gate timing.
// Assumes the plant model closes the flyback loop; the bench drives all other flags.
`timescale 1ns/1ns
`default_nettype none
module testbench;
	// ************************************************************
	// Shortened counts and signals
	// ************************************************************
	localparam logic [11:0] SUP   = 12'h00A;
	localparam logic [11:0] MAXON = 12'h028;
	localparam logic [11:0] LEB   = 12'h004;
	localparam logic [11:0] MINP  = 12'h01E;
	localparam int          O_FB  = 0;
	localparam int          O_OVP = 1;
	localparam int          O_PRT = 2;
	localparam int          O_PFC = 3;
	localparam int          O_PU  = 4;
	localparam int          O_SS  = 5;
	logic        clk, rst, wr_s, rd_s, pfc, fb, pu, ss, opp, ovp, prot, cs, dm, vl;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata, d;
	logic [16:0] drv, flags;
	logic [11:0] on_len, dm_len;
	logic [5:0]  outs;
	int          mismatches, compares, n, k;

	assign flags = drv | {10'h000, cs, 1'b0, vl, dm, 3'h0};
	assign outs  = {ss, pu, pfc, prot, ovp, fb};

	gate_sequencer #(.SUP_CYC(SUP), .MAX_ON_CYC(MAXON), .LEB_CYC(LEB), .MIN_PERIOD_CYC(MINP),
		.PFC_OFF_CYC(12'h050), .PFC_ON_CYC(12'h032)) dut (.REF_CLK(clk), .RST(rst),
		.FLAGS(flags), .PFC_GATE(pfc), .FB_GATE(fb), .FB_CTRL_PULLUP_EN(pu),
		.FB_SOFT_START_EN(ss), .OPP_SAMPLE_EN(opp), .OVP_SAMPLE_EN(ovp), .PROT_LATCHED(prot),
		.REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata));

	flyback_plant plant (.clk(clk), .gate(fb), .on_len(on_len), .demag_len(dm_len),
		.cs_trip(cs), .demag(dm), .valley(vl));

	always #10 clk = ~clk;

	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic test_done;
		if (mismatches == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : test_done

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic setf(input int idx, input logic v);
		@(posedge clk);
		drv[idx] <= v;
	endtask : setf

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr  <= a;
		wdata <= v;
		wr_s  <= 1'b1;
		@(posedge clk);
		wr_s  <= 1'b0;
	endtask : wr

	// Read data stands only in the cycle after the strobe edge
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		d = rdata;
	endtask : rd

	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] exp);
		rd(a);
		chk(what, exp, d & m);
	endtask : rdc

	task automatic wait_out(input int sel, input logic lvl, input int bound);
		n = 0;
		while (outs[sel] !== lvl) begin
			@(posedge clk);
			#1;
			n++;
			if (n > bound) begin
				chk("wait_out", 32'(lvl), 32'(outs[sel]));
				test_done();
			end
		end
	endtask : wait_out

	// Counts flyback gate-high cycles over a window that must stay quiet
	task automatic hold_low(input string what, input int cyc);
		k = 0;
		repeat (cyc) begin
			@(posedge clk);
			#1;
			k += int'(fb);
		end
		chk(what, 0, k);
	endtask : hold_low

	task automatic len_of(input int sel);
		wait_out(sel, 1'b1, 400);
		wait_out(sel, 1'b0, 400);
	endtask : len_of

	// ************************************************************
	// Sequence
	// ************************************************************
	initial begin
		clk = 1'b0; rst = 1'b1; wr_s = 1'b0; rd_s = 1'b0; addr = 8'h00; wdata = 32'h0;
		drv = 17'h00000; on_len = 12'h006; dm_len = 12'h00C; mismatches = 0; compares = 0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk("reset_gates", 3'h4, {pu, fb, pfc});
		chk("reset_softstart", 0, ss);
		rdc("ctrl", gate_seq_pkg::ADDR_CTRL, 32'h3, 32'h3);
		wr(8'h0C, 32'hFFFFFFFF);
		rdc("unmapped", 8'h0C, 32'hFFFFFFFF, 32'h0);
		// PFC gating
		setf(gate_seq_pkg::F_PFC_REQ, 1'b1);
		hold_low("dummy_fb", 1);
		repeat (10) @(posedge clk);
		#1;
		chk("pfc_no_ol", 0, pfc);
		setf(gate_seq_pkg::F_PFC_OL_OK, 1'b1);
		wait_out(O_PFC, 1'b1, 6);
		setf(gate_seq_pkg::F_PFC_OVP, 1'b1);
		wait_out(O_PFC, 1'b0, 4);
		setf(gate_seq_pkg::F_PFC_OVP, 1'b0);
		wait_out(O_PFC, 1'b1, 4);
		wr(gate_seq_pkg::ADDR_CTRL, 32'h1);
		wait_out(O_PFC, 1'b0, 4);
		wr(gate_seq_pkg::ADDR_CTRL, 32'h3);
		// Control pin pull-up
		setf(gate_seq_pkg::F_CTRL_2V5, 1'b1);
		wait_out(O_PU, 1'b0, 4);
		setf(gate_seq_pkg::F_CTRL_2V5, 1'b0);
		wait_out(O_PU, 1'b1, 4);
		// Soft start then first stroke
		setf(gate_seq_pkg::F_OSC, 1'b1);
		setf(gate_seq_pkg::F_VCC_START, 1'b1);
		wait_out(O_SS, 1'b1, 4);
		hold_low("softstart_hold", 40);
		setf(gate_seq_pkg::F_SS_DONE, 1'b1);
		wait_out(O_FB, 1'b1, 300);
		chk("opp_window", 1, opp);
		wait_out(O_SS, 1'b0, 4);
		// Trip at once: on-time held by blanking
		on_len = 12'h000;
		len_of(O_FB);
		chk("blanked_on", 1, 32'(n >= int'(LEB)));
		on_len = 12'h006;
		len_of(O_FB);
		chk("trip_on", 1, 32'(n <= 10));
		dm_len = 12'h000;
		len_of(O_OVP);
		chk("demag_mask", 1, 32'(n >= int'(SUP)));
		dm_len = 12'h00C;
		rd(gate_seq_pkg::ADDR_PERIOD);
		chk("period_max", 1, 32'(d[11:0] < 12'h100));
		chk("period_min", 1, 32'(d[11:0] >= MINP));
		// No stroke without oscillator, nor without demagnetisation
		setf(gate_seq_pkg::F_OSC, 1'b0);
		wait_out(O_FB, 1'b0, 60);
		hold_low("osc_low", 150);
		dm_len = 12'hFFF;
		setf(gate_seq_pkg::F_OSC, 1'b1);
		hold_low("no_demag", 150);
		dm_len = 12'h00C;
		// Faults that stop the flyback and clear by themselves
		for (int i = 0; i < 2; i++) begin
			k = i ? gate_seq_pkg::F_CTRL_SHORT : gate_seq_pkg::F_AUX_OPEN;
			setf(k, 1'b1);
			wait_out(O_FB, 1'b0, 60);
			hold_low("fault_hold", 120);
			setf(i ? gate_seq_pkg::F_CTRL_SHORT : gate_seq_pkg::F_AUX_OPEN, 1'b0);
			wait_out(O_FB, 1'b1, 300);
		end
		// Low-power PFC shutdown and return
		setf(gate_seq_pkg::F_FREQ_RED, 1'b1);
		setf(gate_seq_pkg::F_OSC, 1'b0);
		repeat (150) @(posedge clk);
		#1;
		chk("pfc_lowpower", 0, pfc);
		rdc("status_low", gate_seq_pkg::ADDR_STATUS, 32'h4, 32'h4);
		setf(gate_seq_pkg::F_FREQ_RED, 1'b0);
		setf(gate_seq_pkg::F_OSC, 1'b1);
		wait_out(O_PFC, 1'b1, 400);
		// Overvoltage filter: up one, down two, trip at eight
		for (int i = 0; i < 12; i++) begin
			setf(gate_seq_pkg::F_FB_OVP, (i < 3 || i > 4));
			len_of(O_OVP);
			repeat (2) @(posedge clk);
			rdc("ovp_count", gate_seq_pkg::ADDR_STATUS, 32'hF0,
				32'(i < 3 ? i + 1 : i == 3 ? 1 : i == 4 ? 0 : i - 4) << 4);
		end
		drv[gate_seq_pkg::F_FB_OVP] <= 1'b1;
		wait_out(O_PRT, 1'b1, 400);
		repeat (3) @(posedge clk);
		#1;
		chk("latched_gates", 0, {pfc, fb});
		setf(gate_seq_pkg::F_FB_OVP, 1'b0);
		setf(gate_seq_pkg::F_MAINS_HIGH, 1'b1);
		repeat (20) @(posedge clk);
		#1;
		chk("latch_hold", 1, prot);
		hold_low("latch_fb", 40);
		setf(gate_seq_pkg::F_MAINS_HIGH, 1'b0);
		setf(gate_seq_pkg::F_MAINS_LOW, 1'b1);
		repeat (5) @(posedge clk);
		setf(gate_seq_pkg::F_MAINS_LOW, 1'b0);
		setf(gate_seq_pkg::F_MAINS_HIGH, 1'b1);
		wait_out(O_PRT, 1'b0, 8);
		rdc("count_clear", gate_seq_pkg::ADDR_STATUS, 32'hF0, 32'h0);
		wait_out(O_FB, 1'b1, 400);
		// Maximum on-time then safe restart
		on_len = 12'hFFF;
		len_of(O_FB);
		chk("max_on", 1, 32'(n >= int'(MAXON) - 1 && n <= int'(MAXON) + 1));
		on_len = 12'h006;
		rdc("restarted", gate_seq_pkg::ADDR_STATUS, 32'h2, 32'h2);
		wr(gate_seq_pkg::ADDR_STATUS, 32'h2);
		rdc("restart_clr", gate_seq_pkg::ADDR_STATUS, 32'h2, 32'h0);
		// Control pin far too high
		setf(gate_seq_pkg::F_CTRL_4V5, 1'b1);
		wait_out(O_PRT, 1'b1, 6);
		hold_low("ctrl_latch", 60);
		test_done();
	end
endmodule : testbench
`default_nettype wire
